// ==== hdl/gpio_port_pins.sv ====
// GPIO port with APB registers, pad control, interrupts and triggers
`timescale 1ns/10ps

// Function
// - Up to eight pins, selected by index
// - Per-pin direction; inputs after reset
// - Input interrupt on level or edge types
// - Drive 2/4/8 mA, resets to 2 mA
// - Slew limit only effective at 8 mA
// - Pull-up, pull-down or none; none at reset
// - Optional open drain; push-pull at reset
// - GPIO or peripheral; absent peripheral does nothing
// - Eight-bit mask, bit n is pin n
// - Masked read returns selected pins only
// - Address-masked write updates selected pins together
// - Per-pin enable as ADC start trigger
// - ADC trigger keeps interrupt path alive
// - Per-pin ADC trigger disable stops starts
// - Per-pin enable as DMA start trigger
// - Peripheral drives or receives pin in hardware
module gpio_port_pins #(
    parameter int NUM_PINS = 8,
    parameter logic [7:0] PERIPH_PRESENT = 8'hFF
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Pads
    input wire logic [NUM_PINS-1:0] I_PAD_IN,
    output logic [NUM_PINS-1:0] O_PAD_OUT,
    output logic [NUM_PINS-1:0] O_PAD_OE,
    output logic [NUM_PINS-1:0] O_PULL_UP,
    output logic [NUM_PINS-1:0] O_PULL_DOWN,
    output logic [NUM_PINS-1:0] O_DRIVE_4MA,
    output logic [NUM_PINS-1:0] O_DRIVE_8MA,
    output logic [NUM_PINS-1:0] O_SLEW_LIMIT,
    // Peripheral functions
    input wire logic [NUM_PINS-1:0] I_PERIPH_OUT,
    input wire logic [NUM_PINS-1:0] I_PERIPH_OE,
    output logic [NUM_PINS-1:0] O_PERIPH_IN,
    // Interrupt and triggers
    output logic O_IRQ,
    output logic O_ADC_TRIG,
    output logic O_DMA_TRIG
);
    import gpio_port_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (NUM_PINS < 1 || NUM_PINS > 8) begin : g_bad_pins
        $error("NUM_PINS must lie between 1 and 8");
    end

    localparam int N = NUM_PINS;

    // Decode an APB address into the pin mask it carries
    function automatic logic [N-1:0] addr_mask(input logic [11:0] a);
        logic [7:0] m;
        m = a[MASK_ADDR_LSB+7:MASK_ADDR_LSB];
        return m[N-1:0];
    endfunction

    // Is the address inside the masked data window
    function automatic logic in_data(input logic [11:0] a);
        return (a >= DATA_BASE_OFS) && (a <= DATA_LAST_OFS);
    endfunction

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [N-1:0] data_r, data_nxt; // Output data values
    logic [N-1:0] dir_r, dir_nxt; // Direction
    logic [TYPE_W*N-1:0] type_r, type_nxt; // Interrupt type fields
    logic [N-1:0] int_en_r, int_en_nxt; // Interrupt enables
    logic [N-1:0] int_raw_r, int_raw_nxt; // Sticky status
    logic [N-1:0] psel_r, psel_nxt; // Peripheral select
    logic [DRIVE_W*N-1:0] drive_r, drive_nxt; // Drive fields
    logic [N-1:0] od_r, od_nxt; // Open drain
    logic [PULL_W*N-1:0] pull_r, pull_nxt; // Pull fields
    logic [N-1:0] slew_r, slew_nxt; // Slew limit requests
    logic [N-1:0] adc_en_r, adc_en_nxt; // ADC trigger enables
    logic [N-1:0] dma_en_r, dma_en_nxt; // DMA trigger enables
    logic [31:0] rdata_r, rdata_nxt; // Read data
    logic ready_r, ready_nxt; // Access-phase ready
    logic err_r, err_nxt; // Access-phase error

    // ------------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------------
    logic [N-1:0] pin_level; // Filtered pad levels
    logic [N-1:0] pin_rise; // Rising pulses
    logic [N-1:0] pin_fall; // Falling pulses
    logic [N-1:0] pin_event; // Detected condition per pin

    // Synchronise pads before detection
    gpio_pin_sync #(
        .NUM_PINS(N)
    ) u_sync (
        .clk(I_MCLK),
        .rst_n(I_RESETN),
        .i_pad(I_PAD_IN),
        .o_level(pin_level),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    // Per-pin condition select, inputs only
    always_comb begin
        pin_event = '0;
        for (int i = 0; i < N; i++) begin
            unique case (type_r[TYPE_W*i +: TYPE_W])
                INT_FALLING: pin_event[i] = pin_fall[i];
                INT_RISING: pin_event[i] = pin_rise[i];
                INT_BOTH: pin_event[i] = pin_rise[i] | pin_fall[i];
                INT_LOW: pin_event[i] = ~pin_level[i];
                INT_HIGH: pin_event[i] = pin_level[i];
                default: pin_event[i] = 1'b0; // Unused codes
            endcase
            // Detection lives on GPIO inputs only
            if (dir_r[i] || psel_r[i]) begin
                pin_event[i] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // APB access decode
    // ------------------------------------------------------------------
    logic setup_ph; // Setup cycle seen
    logic wr_ph; // Write takes effect here
    logic [N-1:0] wmask; // Pin mask for data writes
    logic [N-1:0] wbits; // Write data for pins
    logic [N-1:0] clr_bits; // Status clears this cycle

    assign setup_ph = I_PSEL && !I_PENABLE;
    assign wr_ph = I_PSEL && I_PENABLE && ready_r && I_PWRITE && !err_r;
    assign wmask = addr_mask(I_PADDR);
    assign wbits = I_PWDATA[N-1:0];

    // Register writes and sticky status
    always_comb begin
        data_nxt = data_r;
        dir_nxt = dir_r;
        type_nxt = type_r;
        int_en_nxt = int_en_r;
        psel_nxt = psel_r;
        drive_nxt = drive_r;
        od_nxt = od_r;
        pull_nxt = pull_r;
        slew_nxt = slew_r;
        adc_en_nxt = adc_en_r;
        dma_en_nxt = dma_en_r;
        clr_bits = '0;
        if (wr_ph) begin
            if (in_data(I_PADDR)) begin
                // Selected pins change together
                data_nxt = (data_r & ~wmask) | (wbits & wmask);
            end else begin
                unique case (I_PADDR)
                    DIR_OFS: dir_nxt = wbits;
                    INT_TYPE_OFS: type_nxt = I_PWDATA[TYPE_W*N-1:0];
                    INT_EN_OFS: int_en_nxt = wbits;
                    INT_CLR_OFS: clr_bits = wbits;
                    PERIPH_SEL_OFS: psel_nxt = wbits;
                    DRIVE_OFS: drive_nxt = I_PWDATA[DRIVE_W*N-1:0];
                    OPEN_DRAIN_OFS: od_nxt = wbits;
                    PULL_OFS: pull_nxt = I_PWDATA[PULL_W*N-1:0];
                    SLEW_OFS: slew_nxt = wbits;
                    ADC_TRIG_OFS: adc_en_nxt = wbits;
                    DMA_TRIG_OFS: dma_en_nxt = wbits;
                    default: ; // Read-only locations
                endcase
            end
        end
        // New event wins over a clear in the same cycle
        int_raw_nxt = (int_raw_r & ~clr_bits) | pin_event;
    end

    // Read mux and answer for the following access phase
    always_comb begin
        rdata_nxt = 32'h00000000;
        ready_nxt = 1'b0;
        err_nxt = 1'b0;
        if (setup_ph) begin
            ready_nxt = 1'b1;
            if (in_data(I_PADDR)) begin
                // Outputs read back their data, inputs the pad
                rdata_nxt[N-1:0] = ((data_r & dir_r) | (pin_level & ~dir_r))
                    & addr_mask(I_PADDR);
            end else begin
                unique case (I_PADDR)
                    DIR_OFS: rdata_nxt[N-1:0] = dir_r;
                    INT_TYPE_OFS: rdata_nxt[TYPE_W*N-1:0] = type_r;
                    INT_EN_OFS: rdata_nxt[N-1:0] = int_en_r;
                    INT_RAW_OFS: rdata_nxt[N-1:0] = int_raw_r;
                    INT_MASKED_OFS: rdata_nxt[N-1:0] = int_raw_r & int_en_r;
                    INT_CLR_OFS: rdata_nxt = 32'h00000000;
                    PERIPH_SEL_OFS: rdata_nxt[N-1:0] = psel_r;
                    DRIVE_OFS: rdata_nxt[DRIVE_W*N-1:0] = drive_r;
                    OPEN_DRAIN_OFS: rdata_nxt[N-1:0] = od_r;
                    PULL_OFS: rdata_nxt[PULL_W*N-1:0] = pull_r;
                    SLEW_OFS: rdata_nxt[N-1:0] = slew_r;
                    ADC_TRIG_OFS: rdata_nxt[N-1:0] = adc_en_r;
                    DMA_TRIG_OFS: rdata_nxt[N-1:0] = dma_en_r;
                    default: err_nxt = 1'b1; // Unmapped address
                endcase
            end
            // Read-only status locations refuse writes; the write-only clear reads as zero without error
            if (I_PWRITE && (I_PADDR == INT_RAW_OFS
                || I_PADDR == INT_MASKED_OFS)) begin
                rdata_nxt = 32'h00000000;
                err_nxt = 1'b1;
            end
        end
    end

    // Register block
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            data_r <= '0;
            dir_r <= DIR_RST[N-1:0];
            type_r <= INT_TYPE_RST[TYPE_W*N-1:0];
            int_en_r <= '0;
            int_raw_r <= '0;
            psel_r <= PERIPH_SEL_RST[N-1:0];
            drive_r <= DRIVE_RST[DRIVE_W*N-1:0];
            od_r <= OPEN_DRAIN_RST[N-1:0];
            pull_r <= PULL_RST[PULL_W*N-1:0];
            slew_r <= '0;
            adc_en_r <= '0;
            dma_en_r <= '0;
            rdata_r <= 32'h00000000;
            ready_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            data_r <= data_nxt;
            dir_r <= dir_nxt;
            type_r <= type_nxt;
            int_en_r <= int_en_nxt;
            int_raw_r <= int_raw_nxt;
            psel_r <= psel_nxt;
            drive_r <= drive_nxt;
            od_r <= od_nxt;
            pull_r <= pull_nxt;
            slew_r <= slew_nxt;
            adc_en_r <= adc_en_nxt;
            dma_en_r <= dma_en_nxt;
            rdata_r <= rdata_nxt;
            ready_r <= ready_nxt;
            err_r <= err_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Pad drive, interrupt and trigger outputs
    // ------------------------------------------------------------------
    logic [N-1:0] pad_out_r, pad_out_nxt; // Pad output value
    logic [N-1:0] pad_oe_r, pad_oe_nxt; // Pad output enable
    logic [N-1:0] pu_r, pu_nxt; // Pull-up enable
    logic [N-1:0] pd_r, pd_nxt; // Pull-down enable
    logic [N-1:0] d4_r, d4_nxt; // 4 mA select
    logic [N-1:0] d8_r, d8_nxt; // 8 mA select
    logic [N-1:0] sl_r, sl_nxt; // Slew limit active
    logic [N-1:0] pin_in_r, pin_in_nxt; // Level to peripherals
    logic irq_r, irq_nxt; // Interrupt level
    logic adc_r, adc_nxt; // ADC start pulse
    logic dma_r, dma_nxt; // DMA start pulse

    // Per-pin pad control
    always_comb begin
        for (int i = 0; i < N; i++) begin
            logic drv_val;
            logic drv_en;
            drv_val = data_r[i];
            drv_en = dir_r[i];
            if (psel_r[i]) begin
                // Peripheral takes the pin, if it exists
                drv_val = I_PERIPH_OUT[i];
                drv_en = I_PERIPH_OE[i] & PERIPH_PRESENT[i];
            end
            if (od_r[i]) begin
                // Open drain only ever pulls low
                pad_out_nxt[i] = 1'b0;
                pad_oe_nxt[i] = drv_en & ~drv_val;
            end else begin
                pad_out_nxt[i] = drv_val;
                pad_oe_nxt[i] = drv_en;
            end
            pu_nxt[i] = pull_r[PULL_W*i +: PULL_W] == PULL_UP;
            pd_nxt[i] = pull_r[PULL_W*i +: PULL_W] == PULL_DOWN;
            d4_nxt[i] = drive_r[DRIVE_W*i +: DRIVE_W] == DRIVE_4MA;
            d8_nxt[i] = drive_r[DRIVE_W*i +: DRIVE_W] == DRIVE_8MA;
            sl_nxt[i] = slew_r[i] & d8_nxt[i];
            pin_in_nxt[i] = pin_level[i] & psel_r[i] & PERIPH_PRESENT[i];
        end
        irq_nxt = |(int_raw_r & int_en_r);
        // Triggers share detection; interrupt path untouched
        adc_nxt = |(pin_event & adc_en_r);
        dma_nxt = |(pin_event & dma_en_r);
    end

    // Output registers
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pad_out_r <= '0;
            pad_oe_r <= '0;
            pu_r <= '0;
            pd_r <= '0;
            d4_r <= '0;
            d8_r <= '0;
            sl_r <= '0;
            pin_in_r <= '0;
            irq_r <= 1'b0;
            adc_r <= 1'b0;
            dma_r <= 1'b0;
        end else begin
            pad_out_r <= pad_out_nxt;
            pad_oe_r <= pad_oe_nxt;
            pu_r <= pu_nxt;
            pd_r <= pd_nxt;
            d4_r <= d4_nxt;
            d8_r <= d8_nxt;
            sl_r <= sl_nxt;
            pin_in_r <= pin_in_nxt;
            irq_r <= irq_nxt;
            adc_r <= adc_nxt;
            dma_r <= dma_nxt;
        end
    end

    // Port connections, all from flip-flops
    assign O_PRDATA = rdata_r;
    assign O_PREADY = ready_r;
    assign O_PSLVERR = err_r;
    assign O_PAD_OUT = pad_out_r;
    assign O_PAD_OE = pad_oe_r;
    assign O_PULL_UP = pu_r;
    assign O_PULL_DOWN = pd_r;
    assign O_DRIVE_4MA = d4_r;
    assign O_DRIVE_8MA = d8_r;
    assign O_SLEW_LIMIT = sl_r;
    assign O_PERIPH_IN = pin_in_r;
    assign O_IRQ = irq_r;
    assign O_ADC_TRIG = adc_r;
    assign O_DMA_TRIG = dma_r;

endmodule

// ==== inc/gpio_port_pkg.sv ====
// GPIO port constants: register map, codes, resets
package gpio_port_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the APB slave
    // ------------------------------------------------------------------
    localparam logic [11:0] DATA_BASE_OFS = 12'h000; // 0x000-0x3FC, mask=addr[9:2]
    localparam logic [11:0] DATA_LAST_OFS = 12'h3FC; // Last masked data word
    localparam logic [11:0] DIR_OFS = 12'h400; // Direction, 1 = output
    localparam logic [11:0] INT_TYPE_OFS = 12'h404; // 3-bit detect type per pin
    localparam logic [11:0] INT_EN_OFS = 12'h410; // Interrupt enable
    localparam logic [11:0] INT_RAW_OFS = 12'h414; // Sticky status, read only
    localparam logic [11:0] INT_MASKED_OFS = 12'h418; // Status and enable
    localparam logic [11:0] INT_CLR_OFS = 12'h41C; // Write one to clear
    localparam logic [11:0] PERIPH_SEL_OFS = 12'h420; // 1 = peripheral function
    localparam logic [11:0] DRIVE_OFS = 12'h500; // 2-bit drive code per pin
    localparam logic [11:0] OPEN_DRAIN_OFS = 12'h50C; // 1 = open drain
    localparam logic [11:0] PULL_OFS = 12'h510; // 2-bit pull code per pin
    localparam logic [11:0] SLEW_OFS = 12'h518; // Slew limit enable
    localparam logic [11:0] ADC_TRIG_OFS = 12'h530; // ADC trigger enable
    localparam logic [11:0] DMA_TRIG_OFS = 12'h534; // DMA trigger enable

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int MASK_ADDR_LSB = 2; // Pin mask sits at address bits 9:2
    localparam int TYPE_W = 3; // Width of one interrupt type field
    localparam int DRIVE_W = 2; // Width of one drive field
    localparam int PULL_W = 2; // Width of one pull field

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [2:0] INT_FALLING = 3'h0; // Falling edge
    localparam logic [2:0] INT_RISING = 3'h1; // Rising edge
    localparam logic [2:0] INT_BOTH = 3'h2; // Both edges
    localparam logic [2:0] INT_LOW = 3'h3; // Low level
    localparam logic [2:0] INT_HIGH = 3'h4; // High level
    localparam logic [1:0] DRIVE_2MA = 2'h0; // 2 mA
    localparam logic [1:0] DRIVE_4MA = 2'h1; // 4 mA
    localparam logic [1:0] DRIVE_8MA = 2'h2; // 8 mA
    localparam logic [1:0] PULL_NONE = 2'h0; // No pull
    localparam logic [1:0] PULL_UP = 2'h1; // Weak pull-up
    localparam logic [1:0] PULL_DOWN = 2'h2; // Weak pull-down

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] DIR_RST = 8'h00; // All inputs
    localparam logic [7:0] PERIPH_SEL_RST = 8'h00; // All general purpose
    localparam logic [7:0] OPEN_DRAIN_RST = 8'h00; // All push-pull
    localparam logic [23:0] INT_TYPE_RST = 24'h000000; // Falling edge
    localparam logic [15:0] DRIVE_RST = 16'h0000; // All 2 mA
    localparam logic [15:0] PULL_RST = 16'h0000; // All no pull

endpackage

// ==== hdl/gpio_pin_sync.sv ====
// Pad input synchroniser and edge finder for the whole port
`timescale 1ns/10ps
module gpio_pin_sync #(
    parameter int NUM_PINS = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Raw pad levels
    input wire logic [NUM_PINS-1:0] i_pad,
    // Filtered level and edge pulses
    output logic [NUM_PINS-1:0] o_level,
    output logic [NUM_PINS-1:0] o_rise,
    output logic [NUM_PINS-1:0] o_fall
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [NUM_PINS-1:0] s1_r, s2_r, s3_r; // Three-stage chain
    logic [NUM_PINS-1:0] level_r, level_nxt; // Accepted level
    logic [NUM_PINS-1:0] rise_r, rise_nxt; // One-cycle rising pulse
    logic [NUM_PINS-1:0] fall_r, fall_nxt; // One-cycle falling pulse

    // Accept a change only when the second and third stages agree
    always_comb begin
        level_nxt = level_r;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                level_nxt[i] = s3_r[i];
            end
        end
        rise_nxt = level_nxt & ~level_r;
        fall_nxt = ~level_nxt & level_r;
    end

    // Register chain and results
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
            rise_r <= '0;
            fall_r <= '0;
        end else begin
            s1_r <= i_pad;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign o_level = level_r;
    assign o_rise = rise_r;
    assign o_fall = fall_r;

endmodule

// ==== testbench/gpio_port_pins_asserts.sv ====
// Checker of APB answer and pad outputs
`timescale 1ns/10ps
module gpio_port_pins_asserts #(
    parameter int NUM_PINS = 8
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    // APB
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    // Pad control
    input wire logic [NUM_PINS-1:0] O_PAD_OE,
    input wire logic [NUM_PINS-1:0] O_PULL_UP,
    input wire logic [NUM_PINS-1:0] O_PULL_DOWN,
    input wire logic [NUM_PINS-1:0] O_DRIVE_4MA,
    input wire logic [NUM_PINS-1:0] O_DRIVE_8MA,
    input wire logic [NUM_PINS-1:0] O_SLEW_LIMIT
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);
    // Setup phase of a transfer
    sequence setup_s;
        I_PSEL && !I_PENABLE;
    endsequence
    // One access cycle answered, then quiet
    sequence answer_s;
        O_PREADY ##1 !O_PREADY;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> answer_s)
        else $error("ready not one cycle");
    ready_in_access_a: assert property (O_PREADY |->
        I_PSEL && I_PENABLE && $past(I_PSEL && !I_PENABLE))
        else $error("ready off access");
    error_with_ready_a: assert property (O_PSLVERR |->
        O_PREADY && O_PRDATA == 32'h0)
        else $error("bad error answer");
    reset_input_a: assert property (!$past(I_RESETN) |->
        O_PAD_OE == '0 && (O_PULL_UP | O_PULL_DOWN) == '0)
        else $error("pad active at reset");
    reset_drive_a: assert property (!$past(I_RESETN) |->
        (O_DRIVE_4MA | O_DRIVE_8MA) == '0)
        else $error("drive at reset");
    drive_one_a: assert property ((O_DRIVE_4MA & O_DRIVE_8MA) == '0)
        else $error("two drives");
    slew_8ma_a: assert property ((O_SLEW_LIMIT & ~O_DRIVE_8MA) == '0)
        else $error("slew without 8 mA");
    pull_one_a: assert property ((O_PULL_UP & O_PULL_DOWN) == '0)
        else $error("two pulls");
endmodule

bind gpio_port_pins gpio_port_pins_asserts #(.NUM_PINS(NUM_PINS))
    gpio_port_pins_asserts_i (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PAD_OE(O_PAD_OE),
    .O_PULL_UP(O_PULL_UP), .O_PULL_DOWN(O_PULL_DOWN),
    .O_DRIVE_4MA(O_DRIVE_4MA), .O_DRIVE_8MA(O_DRIVE_8MA),
    .O_SLEW_LIMIT(O_SLEW_LIMIT));

// ==== testbench/gpio_pad_model.sv ====
// Pad wires, pulls and far-side driver
`timescale 1ns/10ps
module gpio_pad_model (
    // Clock for the floating pattern
    input wire logic i_clk,
    // Device pad control
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_pu,
    input wire logic [7:0] i_pd,
    // Far-side driver
    input wire logic [7:0] i_ext_en,
    input wire logic [7:0] i_ext_val,
    // Resolved pad level
    output logic [7:0] o_pad
);
    logic [7:0] float_r = 8'h55; // Undriven pin toggles
    // Floating pattern
    always_ff @(posedge i_clk) begin
        float_r <= ~float_r;
    end
    // Device drive wins, then far side, then weak pull
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i_oe[i]) o_pad[i] = i_out[i];
            else if (i_ext_en[i]) o_pad[i] = i_ext_val[i];
            else if (i_pu[i] ^ i_pd[i]) o_pad[i] = i_pu[i];
            else o_pad[i] = float_r[i];
        end
    end
endmodule

// ==== testbench/gpio_port_pins_bench.sv ====
// Bench of the GPIO port
`timescale 1ns/10ps
module gpio_port_pins_bench;
    import gpio_port_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, irq, adc, dma;
    logic [7:0] pad, pout, poe, pu, pd, d4, d8, slew, pin_in;
    logic [7:0] per_out = 8'h00, per_oe = 8'h00;
    logic [7:0] ext_en = 8'hFF, ext_val = 8'h00;
    int num_errors = 0, n_tests = 0, cyc = 0;
    gpio_port_pins #(.NUM_PINS(8), .PERIPH_PRESENT(8'h0F)) gpio_port_pins_i (
        .I_MCLK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_PAD_IN(pad), .O_PAD_OUT(pout), .O_PAD_OE(poe), .O_PULL_UP(pu),
        .O_PULL_DOWN(pd), .O_DRIVE_4MA(d4), .O_DRIVE_8MA(d8),
        .O_SLEW_LIMIT(slew), .I_PERIPH_OUT(per_out), .I_PERIPH_OE(per_oe),
        .O_PERIPH_IN(pin_in), .O_IRQ(irq), .O_ADC_TRIG(adc),
        .O_DMA_TRIG(dma));
    gpio_pad_model gpio_pad_model_i (.i_clk(clk), .i_out(pout), .i_oe(poe),
        .i_pu(pu), .i_pd(pd), .i_ext_en(ext_en), .i_ext_val(ext_val),
        .o_pad(pad));
    // Clock and hang limit
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            num_errors++;
            wrap_up();
        end
    end
    // Helpers
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Pin 0 rise, count pulses
    task automatic rise_count(output int na, output int nd);
        na = 0;
        nd = 0;
        ext_val <= 8'h01;
        repeat (10) begin
            @(posedge clk);
            na += (adc === 1'b1);
            nd += (dma === 1'b1);
        end
        ext_val <= 8'h00;
        wt(10);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Scenarios
    task automatic t_reset();
        rchk("dir", DIR_OFS, 32'h0);
        rchk("drive", DRIVE_OFS, 32'h0);
        rchk("pull", PULL_OFS, 32'h0);
        rchk("open drain", OPEN_DRAIN_OFS, 32'h0);
        rchk("periph sel", PERIPH_SEL_OFS, 32'h0);
        chk("oe", poe, 8'h00);
        $display("reset done");
    endtask
    task automatic t_data();
        wr(DIR_OFS, 32'hFF);
        wr(12'h024, 32'hFF);
        wt(2);
        chk("out mask 09", pout, 8'h09);
        wr(12'h3F8, 32'h0A);
        wt(2);
        chk("out mask FE", pout, 8'h0B);
        rchk("rd mask 06", 12'h018, 32'h02);
        wr(DIR_OFS, 32'h00);
        ext_val <= 8'hA5;
        wt(6);
        rchk("in mask 0F", 12'h03C, 32'h05);
        $display("data done");
    endtask
    task automatic t_pad();
        wr(DRIVE_OFS, 32'h39);
        wr(SLEW_OFS, 32'h07);
        wr(PULL_OFS, 32'h09);
        wt(2);
        chk("4ma", d4, 8'h01);
        chk("8ma", d8, 8'h02);
        chk("slew", slew, 8'h02);
        chk("pulls", {pd, pu}, 16'h0201);
        wr(DIR_OFS, 32'h01);
        wr(OPEN_DRAIN_OFS, 32'h01);
        wr(12'h3FC, 32'h01);
        wt(2);
        chk("od high", poe, 8'h00);
        wr(12'h3FC, 32'h00);
        wt(2);
        chk("od low", {poe, pout}, 16'h0100);
        wr(DIR_OFS, 32'h00);
        wr(OPEN_DRAIN_OFS, 32'h00);
        $display("pad done");
    endtask
    task automatic t_irq();
        for (int t = 0; t < 5; t++) begin
            wr(INT_TYPE_OFS, t);
            ext_val <= 8'h01;
            wt(8);
            wr(INT_CLR_OFS, 32'hFF);
            apb(1'b0, INT_RAW_OFS, 32'h0);
            chk("raw high", rd[0], t == 4);
            ext_val <= 8'h00;
            wt(8);
            apb(1'b0, INT_RAW_OFS, 32'h0);
            chk("raw low", rd[0], t != 1);
        end
        wt(2);
        chk("irq masked", irq, 1'b0);
        wr(INT_EN_OFS, 32'h01);
        wt(2);
        chk("irq on", irq, 1'b1);
        rchk("masked", INT_MASKED_OFS, 32'h01);
        wr(INT_RAW_OFS, 32'hFF);
        chk("ro write err", err, 1'b1);
        rchk("raw kept", INT_RAW_OFS, 32'h01);
        rchk("unmapped", 12'h600, 32'h0);
        chk("unmapped err", err, 1'b1);
        rchk("clr reads 0", INT_CLR_OFS, 32'h0);
        wr(INT_TYPE_OFS, {29'h0, INT_RISING});
        wr(INT_CLR_OFS, 32'hFF);
        wt(2);
        chk("irq cleared", irq, 1'b0);
        $display("interrupt done");
    endtask
    task automatic t_trig();
        int na, nd;
        wr(ADC_TRIG_OFS, 32'h01);
        rise_count(na, nd);
        chk("adc pulses", na, 1);
        chk("dma idle", nd, 0);
        chk("irq with adc", irq, 1'b1);
        wr(ADC_TRIG_OFS, 32'h00);
        wr(DMA_TRIG_OFS, 32'h01);
        rise_count(na, nd);
        chk("adc off", na, 0);
        chk("dma pulses", nd, 1);
        $display("trigger done");
    endtask
    task automatic t_periph();
        wr(PERIPH_SEL_OFS, 32'h81);
        per_out <= 8'hFF;
        per_oe <= 8'hFF;
        wt(2);
        chk("periph oe", poe, 8'h01);
        chk("periph out", pout[0], 1'b1);
        per_oe <= 8'h00;
        ext_val <= 8'h81;
        wt(6);
        chk("periph in", pin_in, 8'h01);
        $display("peripheral done");
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_data();
        t_pad();
        t_irq();
        t_trig();
        t_periph();
        wrap_up();
    end
endmodule
